// file: verilog/adcacc_ctrl.sv
`timescale 1ns/1ps
`include "adcacc_defs.svh"

module adcacc_ctrl
   import adcacc_pkg::*;
(
   // Clock and reset
   input  wire logic          core_clk_in,
   input  wire logic          resetn_in,
   // Special-function register port
   input  wire logic [7:0]    sfr_addr_in,
   input  wire logic [3:0]    sfr_page_in,
   input  wire logic          sfr_wr_in,
   input  wire logic          sfr_rd_in,
   input  wire logic [7:0]    sfr_wdata_in,
   output logic      [7:0]    sfr_rdata_out,
   // Converter mode bits from the main control register
   input  wire logic          burst_mode_enable_in,
   input  wire logic          converter_enable_in,
   // Converter handshake
   input  wire logic          start_conv_in,
   output logic               conv_request_out,
   input  wire logic          conv_done_in,
   input  wire logic [9:0]    conv_data_in,
   // Status
   output logic               converter_powered_out,
   output logic               burst_busy_out,
   output adcacc_pkg::adcacc_word_t result_word_out
);
   import adcacc_pkg::*;

   logic          accumulate_enable_ff;
   logic [2:0]    result_format_select_ff;
   logic [2:0]    burst_repeat_count_ff;
   logic [3:0]    powerup_delay_setting_ff;
   adcacc_word_t  acc_ff;
   adcacc_state_e state_ff;
   logic [6:0]    conv_left_ff;
   logic [4:0]    unit_left_ff;
   logic          tick;
   logic          wr_cfg, wr_pwr, wr_hi, wr_lo;
   logic          sample_first;
   adcacc_word_t  formatted;

   // Repeat count decode; reserved codes give one conversion
   function automatic logic [6:0] rpt_to_count(input logic [2:0] code);
      case (code)
         3'h1:    rpt_to_count = 7'd4;
         3'h2:    rpt_to_count = 7'd8;
         3'h3:    rpt_to_count = 7'd16;
         3'h4:    rpt_to_count = 7'd32;
         3'h5:    rpt_to_count = 7'd64;
         default: rpt_to_count = 7'd1;
      endcase
   endfunction : rpt_to_count

   // Address decode; config and power-up time per page, result registers ignore the page
   assign wr_cfg = sfr_wr_in && sfr_addr_in == `ADCACC_ACC_CFG_ADDR
                   && sfr_page_in == `ADCACC_PAGE_ACC;
   assign wr_pwr = sfr_wr_in && sfr_addr_in == `ADCACC_PWR_TIME_ADDR
                   && sfr_page_in == `ADCACC_PAGE_PWR;
   assign wr_hi  = sfr_wr_in && sfr_addr_in == `ADCACC_RES_HIGH_ADDR;
   assign wr_lo  = sfr_wr_in && sfr_addr_in == `ADCACC_RES_LOW_ADDR;

   // Configuration register
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         accumulate_enable_ff    <= `ADCACC_AE_RST;
         result_format_select_ff <= 3'h0;
         burst_repeat_count_ff   <= 3'h0;
      end else if (wr_cfg) begin
         accumulate_enable_ff    <= sfr_wdata_in[`ADCACC_AE_BIT];
         result_format_select_ff <=
            sfr_wdata_in[`ADCACC_FMT_MSB:`ADCACC_FMT_LSB];
         burst_repeat_count_ff   <=
            sfr_wdata_in[`ADCACC_RPT_MSB:`ADCACC_RPT_LSB];
      end
   end

   // Power-up time: only the low nibble is stored
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         powerup_delay_setting_ff <= `ADCACC_PWR_TIME_RST;
      end else if (wr_pwr) begin
         // Upper bits dropped
         powerup_delay_setting_ff <= sfr_wdata_in[`ADCACC_PWR_MSB:0];
      end
   end

   // Result formatting on read-back
   always_comb begin
      case (result_format_select_ff)
         3'h1:    formatted = acc_ff >> 1;
         3'h2:    formatted = acc_ff >> 2;
         3'h3:    formatted = acc_ff >> 3;
         3'h4:    formatted = {acc_ff[9:0], 6'h00};
         default: formatted = acc_ff;
      endcase
   end

   // Read mux; write-only and unused bits read zero
   always_comb begin
      sfr_rdata_out = 8'h00;
      if (sfr_rd_in && sfr_addr_in == `ADCACC_ACC_CFG_ADDR
          && sfr_page_in == `ADCACC_PAGE_ACC) begin
         sfr_rdata_out = {2'b00, result_format_select_ff,
                          burst_repeat_count_ff};
      end else if (sfr_rd_in && sfr_addr_in == `ADCACC_PWR_TIME_ADDR
                   && sfr_page_in == `ADCACC_PAGE_PWR) begin
         sfr_rdata_out = {4'h0, powerup_delay_setting_ff};
      end else if (sfr_rd_in && sfr_addr_in == `ADCACC_RES_HIGH_ADDR) begin
         sfr_rdata_out = formatted[15:8];
      end else if (sfr_rd_in && sfr_addr_in == `ADCACC_RES_LOW_ADDR) begin
         sfr_rdata_out = formatted[7:0];
      end
   end

   // Burst sequencer
   assign sample_first = (state_ff == ADCACC_CONV)
                         && (conv_left_ff
                             == rpt_to_count(burst_repeat_count_ff));

   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_ff     <= ADCACC_IDLE;
         conv_left_ff <= 7'd0;
         unit_left_ff <= 5'd0;
      end else begin
         case (state_ff)
            ADCACC_IDLE: begin
               if (start_conv_in && burst_mode_enable_in) begin
                  // Burst length from the repeat code
                  conv_left_ff <= rpt_to_count(burst_repeat_count_ff);
                  if (converter_enable_in) begin
                     state_ff <= ADCACC_CONV;
                  end else begin
                     unit_left_ff <= {1'b0, powerup_delay_setting_ff}
                                     + 5'd1;
                     state_ff     <= ADCACC_WAKE;
                  end
               end else if (start_conv_in) begin
                  conv_left_ff <= 7'd1;
                  state_ff     <= ADCACC_CONV;
               end
            end
            ADCACC_WAKE: begin
               if (tick) begin
                  unit_left_ff <= unit_left_ff - 5'd1;
                  if (unit_left_ff == 5'd1) begin
                     state_ff <= ADCACC_CONV;
                  end
               end
            end
            ADCACC_CONV: begin
               state_ff <= ADCACC_WAIT;
            end
            ADCACC_WAIT: begin
               if (conv_done_in) begin
                  conv_left_ff <= conv_left_ff - 7'd1;
                  state_ff <= (conv_left_ff == 7'd1) ? ADCACC_IDLE
                                                     : ADCACC_CONV;
               end
            end
            default: state_ff <= ADCACC_IDLE;
         endcase
      end
   end

   // Marks first result of a burst so it replaces the old sum
   logic first_pending_ff;
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         first_pending_ff <= 1'b0;
      end else if (sample_first) begin
         first_pending_ff <= 1'b1;
      end else if (conv_done_in) begin
         first_pending_ff <= 1'b0;
      end
   end

   // Accumulator; software writes win over a finishing conversion
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         acc_ff <= 16'h0000;
      end else if (wr_hi) begin
         acc_ff[15:8] <= sfr_wdata_in;
      end else if (wr_lo) begin
         acc_ff[7:0] <= sfr_wdata_in;
      end else if (conv_done_in && state_ff == ADCACC_WAIT) begin
         if (burst_mode_enable_in) begin
            acc_ff <= first_pending_ff ? {6'h00, conv_data_in}
                                       : acc_ff + {6'h00, conv_data_in};
         end else if (accumulate_enable_ff) begin
            acc_ff <= acc_ff + {6'h00, conv_data_in};
         end else begin
            acc_ff <= {6'h00, conv_data_in};
         end
      end
   end

   adcacc_unit_tick u_unit_tick (
      .core_clk_in (core_clk_in),
      .resetn_in   (resetn_in),
      .run_in      (state_ff == ADCACC_WAKE),
      .tick_out    (tick)
   );

   // Power state: burst off follows enable; burst on adds the convert and wait states, not the power-up wait
   assign converter_powered_out = burst_mode_enable_in
      ? (converter_enable_in || (state_ff == ADCACC_CONV)
         || (state_ff == ADCACC_WAIT))
      : converter_enable_in;
   assign conv_request_out = state_ff == ADCACC_CONV;
   assign burst_busy_out   = state_ff != ADCACC_IDLE;
   assign result_word_out  = formatted;

   // Power-up wait lasts (setting+1) units of 20 cycles
   property p_wake_len;
      @(posedge core_clk_in) disable iff (!resetn_in)
      ($rose(state_ff == ADCACC_WAKE) && powerup_delay_setting_ff == 4'h0)
      |-> (state_ff == ADCACC_WAKE)[*8] ##[1:20] state_ff == ADCACC_CONV;
   endproperty
   a_wake_len: assert property (p_wake_len)
      else $error("power-up wait length wrong");

   property p_enabled_no_wait;
      @(posedge core_clk_in) disable iff (!resetn_in)
      (state_ff == ADCACC_IDLE && start_conv_in && burst_mode_enable_in
       && converter_enable_in) |=> conv_request_out;
   endproperty
   a_enabled_no_wait: assert property (p_enabled_no_wait)
      else $error("enabled burst did not start at once");

   property p_lowpower_waits;
      @(posedge core_clk_in) disable iff (!resetn_in)
      (state_ff == ADCACC_IDLE && start_conv_in && burst_mode_enable_in
       && !converter_enable_in) |=> !conv_request_out [*8];
   endproperty
   a_lowpower_waits: assert property (p_lowpower_waits)
      else $error("low-power burst started too early");

   property p_power_follows;
      @(posedge core_clk_in) disable iff (!resetn_in)
      !burst_mode_enable_in |-> converter_powered_out == converter_enable_in;
   endproperty
   a_power_follows: assert property (p_power_follows)
      else $error("power state not following enable");

   property p_sleep_after;
      @(posedge core_clk_in) disable iff (!resetn_in)
      (burst_mode_enable_in && !converter_enable_in && state_ff == ADCACC_IDLE)
      |-> !converter_powered_out;
   endproperty
   a_sleep_after: assert property (p_sleep_after)
      else $error("converter powered after burst");

   property p_ae_reads_zero;
      @(posedge core_clk_in) disable iff (!resetn_in)
      1'b1 |-> !sfr_rdata_out[`ADCACC_AE_BIT] || sfr_addr_in != 8'hba;
   endproperty
   a_ae_reads_zero: assert property (p_ae_reads_zero)
      else $error("write-only bit read back");

   property p_single_load;
      @(posedge core_clk_in) disable iff (!resetn_in)
      (conv_done_in && state_ff == ADCACC_WAIT && !burst_mode_enable_in
       && !accumulate_enable_ff && !sfr_wr_in)
      |=> acc_ff == {6'h00, $past(conv_data_in)};
   endproperty
   a_single_load: assert property (p_single_load)
      else $error("single result not loaded");

   property p_accumulate;
      @(posedge core_clk_in) disable iff (!resetn_in)
      (conv_done_in && state_ff == ADCACC_WAIT && !burst_mode_enable_in
       && accumulate_enable_ff && !sfr_wr_in)
      |=> acc_ff == $past(acc_ff) + {6'h00, $past(conv_data_in)};
   endproperty
   a_accumulate: assert property (p_accumulate)
      else $error("accumulation sum wrong");

   property p_left_justify;
      @(posedge core_clk_in) disable iff (!resetn_in)
      result_format_select_ff == 3'h4 |-> result_word_out[5:0] == 6'h00;
   endproperty
   a_left_justify: assert property (p_left_justify)
      else $error("left justify low bits not zero");
endmodule : adcacc_ctrl

// file: verilog/adcacc_defs.svh
`ifndef ADCACC_DEFS_SVH
`define ADCACC_DEFS_SVH

// Register offsets (config and power-up time share one address, selected by page)
`define ADCACC_ACC_CFG_ADDR    8'hba
`define ADCACC_PWR_TIME_ADDR   8'hba
`define ADCACC_RES_HIGH_ADDR   8'hbe
`define ADCACC_RES_LOW_ADDR    8'hbd
`define ADCACC_PAGE_ACC        4'h0
`define ADCACC_PAGE_PWR        4'hf

// Field positions
`define ADCACC_AE_BIT          6
`define ADCACC_FMT_MSB         5
`define ADCACC_FMT_LSB         3
`define ADCACC_RPT_MSB         2
`define ADCACC_RPT_LSB         0
`define ADCACC_PWR_MSB         3

// Reset values
`define ADCACC_ACC_CFG_RST     8'h00
`define ADCACC_AE_RST          1'b0
`define ADCACC_PWR_TIME_RST    4'hf

// Timing: one power-up unit is 400 ns at a 20 ns clock
`define ADCACC_PWR_UNIT_NS     400
`define ADCACC_CLK_PERIOD_NS   20
`define ADCACC_PWR_UNIT_CYC    (`ADCACC_PWR_UNIT_NS / `ADCACC_CLK_PERIOD_NS)

`endif

// file: verilog/adcacc_pkg.sv
package adcacc_pkg;
   // Burst sequencer states
   typedef enum logic [1:0] {
      ADCACC_IDLE,
      ADCACC_WAKE,
      ADCACC_CONV,
      ADCACC_WAIT
   } adcacc_state_e;

   typedef logic [15:0] adcacc_word_t;
endpackage : adcacc_pkg

// file: verilog/adcacc_unit_tick.sv
`timescale 1ns/1ps
`include "adcacc_defs.svh"

// Divider giving one pulse per 400 ns power-up unit
module adcacc_unit_tick (
   // Clock and reset
   input  wire logic core_clk_in,
   input  wire logic resetn_in,
   // Control
   input  wire logic run_in,
   output logic      tick_out
);
   localparam int unsigned UNIT_CYC = `ADCACC_PWR_UNIT_CYC;
   logic [7:0] cnt_ff;

   // Restarts from zero whenever the wait is not running
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cnt_ff <= 8'h00;
      end else if (!run_in || cnt_ff == 8'(UNIT_CYC - 1)) begin
         cnt_ff <= 8'h00;
      end else begin
         cnt_ff <= cnt_ff + 8'h01;
      end
   end

   assign tick_out = run_in && (cnt_ff == 8'(UNIT_CYC - 1));
endmodule : adcacc_unit_tick

// file: bench/adcacc_ctrl_tb_top.sv
`timescale 1ns/1ps
`include "adcacc_defs.svh"

module adcacc_ctrl_tb_top;
   import adcacc_pkg::*;

   // Expected reads of 0x2d5 per format code, code 5 reserved
   localparam logic [15:0] FMT_EXP [0:5] = '{16'h02d5, 16'h016a,
      16'h00b5, 16'h005a, 16'hb540, 16'h02d5};
   // Conversions per repeat code, codes 6 and 7 reserved
   localparam int RPT_N [0:7] = '{1, 4, 8, 16, 32, 64, 1, 1};

   logic         core_clk_in;
   logic         resetn_in;
   logic [7:0]   sfr_addr_in;
   logic [3:0]   sfr_page_in;
   logic         sfr_wr_in;
   logic         sfr_rd_in;
   logic [7:0]   sfr_wdata_in;
   logic [7:0]   sfr_rdata_out;
   logic         burst_mode_enable_in;
   logic         converter_enable_in;
   logic         start_conv_in;
   logic         conv_request_out;
   logic         conv_done_in;
   logic [9:0]   conv_data_in;
   logic         converter_powered_out;
   logic         burst_busy_out;
   adcacc_word_t result_word_out;
   int           fail_count;
   int           check_count;
   int           cyc_count;
   int           n;
   int           lat;
   logic [7:0]   rd_val;

   adcacc_ctrl adcacc_ctrl_inst (
      .core_clk_in(core_clk_in), .resetn_in(resetn_in),
      .sfr_addr_in(sfr_addr_in), .sfr_page_in(sfr_page_in),
      .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
      .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
      .burst_mode_enable_in(burst_mode_enable_in),
      .converter_enable_in(converter_enable_in),
      .start_conv_in(start_conv_in), .conv_request_out(conv_request_out),
      .conv_done_in(conv_done_in), .conv_data_in(conv_data_in),
      .converter_powered_out(converter_powered_out),
      .burst_busy_out(burst_busy_out), .result_word_out(result_word_out));

   // Free-running 50 MHz clock
   initial begin
      core_clk_in = 1'b0;
      forever #10 core_clk_in = ~core_clk_in;
   end

   // Hang guard, far above the few hundred cycles the run needs
   always @(posedge core_clk_in) begin
      cyc_count++;
      if (cyc_count == 20000) begin
         fail_count++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Write strobe is one cycle; next call waits a fresh edge
   task automatic sfr_wr(input logic [3:0] pg, input logic [7:0] a,
                         input logic [7:0] d);
      @(posedge core_clk_in);
      sfr_page_in  <= pg;
      sfr_addr_in  <= a;
      sfr_wdata_in <= d;
      sfr_wr_in    <= 1'b1;
      @(posedge core_clk_in);
      sfr_wr_in    <= 1'b0;
      // Let the written register settle before callers look at outputs
      #1;
   endtask : sfr_wr

   task automatic sfr_rd(input logic [3:0] pg, input logic [7:0] a,
                         output logic [7:0] d);
      @(posedge core_clk_in);
      sfr_page_in <= pg;
      sfr_addr_in <= a;
      sfr_rd_in   <= 1'b1;
      @(posedge core_clk_in);
      d = sfr_rdata_out;
      sfr_rd_in   <= 1'b0;
   endtask : sfr_rd

   // One start pulse; answer every request until the sequencer idles
   task automatic conv_run(input logic [9:0] d, output int cnt,
                           output int first);
      cnt   = 0;
      first = 0;
      @(posedge core_clk_in);
      start_conv_in <= 1'b1;
      @(posedge core_clk_in);
      start_conv_in <= 1'b0;
      for (int c = 1; c < 3000; c++) begin
         @(posedge core_clk_in);
         conv_done_in <= (conv_request_out === 1'b1);
         conv_data_in <= d;
         if (conv_request_out === 1'b1) begin
            if (cnt == 0) first = c;
            cnt++;
         end else if (cnt > 0 && burst_busy_out === 1'b0) begin
            break;
         end
      end
   endtask : conv_run

   // Main sequence: row table first, then the awkward cases
   initial begin
      resetn_in = 1'b0;
      sfr_addr_in = 8'h00;
      sfr_page_in = 4'h0;
      sfr_wr_in = 1'b0;
      sfr_rd_in = 1'b0;
      sfr_wdata_in = 8'h00;
      burst_mode_enable_in = 1'b0;
      converter_enable_in = 1'b0;
      start_conv_in = 1'b0;
      conv_done_in = 1'b0;
      conv_data_in = 10'h000;
      fail_count = 0;
      check_count = 0;
      cyc_count = 0;
      repeat (12) @(posedge core_clk_in);
      resetn_in <= 1'b1;
      sfr_rd(`ADCACC_PAGE_ACC, `ADCACC_ACC_CFG_ADDR, rd_val);
      chk({8'h00, rd_val}, 16'h0000);
      sfr_rd(`ADCACC_PAGE_PWR, `ADCACC_PWR_TIME_ADDR, rd_val);
      chk({8'h00, rd_val}, 16'h000f);
      chk(result_word_out, 16'h0000);
      for (int e = 0; e < 2; e++) begin
         @(posedge core_clk_in);
         converter_enable_in <= e[0];
         @(posedge core_clk_in);
         chk({15'h0, converter_powered_out}, {15'h0, e[0]});
      end
      sfr_wr(`ADCACC_PAGE_PWR, `ADCACC_PWR_TIME_ADDR, 8'hf5);
      sfr_rd(`ADCACC_PAGE_PWR, `ADCACC_PWR_TIME_ADDR, rd_val);
      chk({8'h00, rd_val}, 16'h0005);
      conv_run(10'h155, n, lat);
      conv_run(10'h2d5, n, lat);
      chk(result_word_out, 16'h02d5);
      // Repeat count stays 000 while burst is off
      for (int i = 0; i < 6; i++) begin
         sfr_wr(`ADCACC_PAGE_ACC, `ADCACC_ACC_CFG_ADDR,
                {2'b00, i[2:0], 3'b0});
         chk(result_word_out, FMT_EXP[i]);
         sfr_rd(`ADCACC_PAGE_ACC, `ADCACC_RES_HIGH_ADDR, rd_val);
         chk({8'h00, rd_val}, {8'h00, FMT_EXP[i][15:8]});
         sfr_rd(`ADCACC_PAGE_ACC, `ADCACC_RES_LOW_ADDR, rd_val);
         chk({8'h00, rd_val}, {8'h00, FMT_EXP[i][7:0]});
      end
      sfr_wr(`ADCACC_PAGE_ACC, `ADCACC_ACC_CFG_ADDR, 8'h40);
      sfr_rd(`ADCACC_PAGE_ACC, `ADCACC_ACC_CFG_ADDR, rd_val);
      chk({8'h00, rd_val}, 16'h0000);
      conv_run(10'h100, n, lat);
      conv_run(10'h0ff, n, lat);
      chk(result_word_out, 16'h04d4);
      sfr_wr(`ADCACC_PAGE_ACC, `ADCACC_RES_HIGH_ADDR, 8'h00);
      sfr_wr(`ADCACC_PAGE_ACC, `ADCACC_RES_LOW_ADDR, 8'h00);
      conv_run(10'h123, n, lat);
      chk(result_word_out, 16'h0123);
      // Bursts with the converter kept enabled
      @(posedge core_clk_in);
      burst_mode_enable_in <= 1'b1;
      for (int r = 0; r < 8; r++) begin
         sfr_wr(`ADCACC_PAGE_ACC, `ADCACC_ACC_CFG_ADDR, {5'h00, r[2:0]});
         conv_run(10'h001, n, lat);
         chk(16'(n), 16'(RPT_N[r]));
         chk(result_word_out, 16'(RPT_N[r]));
         chk(16'(lat), 16'h0001);
         chk({15'h0, converter_powered_out}, 16'h0001);
      end
      // Low-power bursts wait the programmed wake time first
      @(posedge core_clk_in);
      converter_enable_in <= 1'b0;
      sfr_wr(`ADCACC_PAGE_ACC, `ADCACC_ACC_CFG_ADDR, 8'h01);
      for (int p = 0; p < 4; p += 2) begin
         sfr_wr(`ADCACC_PAGE_PWR, `ADCACC_PWR_TIME_ADDR, 8'(p));
         conv_run(10'h002, n, lat);
         chk(16'(n), 16'h0004);
         chk(result_word_out, 16'h0008);
         chk({15'h0, lat >= 20 * (p + 1) && lat <= 20 * (p + 1) + 3},
             16'h0001);
         chk({15'h0, converter_powered_out}, 16'h0000);
      end
      end_sim();
   end
endmodule : adcacc_ctrl_tb_top
